//--- hdl/rst_params.svh
`ifndef RST_PARAMS_SVH
`define RST_PARAMS_SVH
// register byte addresses (own map)
`define RST_REG_CTRL 8'h00
`define RST_REG_STAT 8'h04
`define RST_REG_VEC 8'h08
`define RST_REG_FETCH 8'h0C
`define RST_REG_PC 8'h10
`define RST_REG_CORE 8'h14
// control register fields
`define RST_CTRL_HF_BIT 7
`define RST_CTRL_LF_BIT 6
`define RST_CTRL_WDT_BIT 0
`define RST_CTRL_RESET 8'hC1
// stretch length exponent and machine cycle length in clocks
`define RST_STRETCH_EXP 20
`define RST_MCYC_CLKS 4
`define RST_EXT_MIN_MCYC 3
// memory map
`define RST_TRAP_LO 16'h0000
`define RST_TRAP_HI 16'h043F
`define RST_RAM_LO 16'h0040
`define RST_RAM_HI_DEF 16'h013F
`define RST_ROM_LO_DEF 16'hE000
`define RST_DIRECT_HI 16'h00FF
`define RST_BANK_HI 16'h00BF
`define RST_SFR_HI 16'h003F
`define RST_IVEC_LO 16'hFFE0
`define RST_CVEC_LO 16'hFFC0
`define RST_VEC_HI 16'hFFFF
`define RST_VEC_LO 16'hFFFE
`define RST_PREFETCH 16'h0002
`define RST_RESP_OKAY 2'b00
`define RST_RESP_DECERR 2'b11
`endif

//--- hdl/rst_pkg.sv
package rst_pkg;
  typedef enum logic [3:0] {
    RST_ST_HOLD = 4'b0001,
    RST_ST_VLO = 4'b0010,
    RST_ST_VHI = 4'b0100,
    RST_ST_RUN = 4'b1000
  } rst_state_t;
  typedef enum logic [2:0] {
    RST_RG_NONE = 3'd0,
    RST_RG_SFR = 3'd1,
    RST_RG_RAM = 3'd2,
    RST_RG_DBR = 3'd3,
    RST_RG_ROM = 3'd4
  } rst_region_t;
endpackage

//--- hdl/rst_sync3.sv
// three-stage pin synchroniser; change accepted once stages two and three agree
module rst_sync3 (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic pin,
  output logic level
);
  logic [2:0] sh;
  // stage shift, pin idles high
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh <= 3'b111;
      level <= 1'b1;
    end else if (clk_en) begin
      sh <= {sh[1:0], pin};
      if (sh[1] == sh[2]) begin
        level <= sh[2];
      end
    end
  end
endmodule

//--- hdl/rst_seq.sv
`include "rst_params.svh"
// How it works
// - four reset sources: pin, trap, watchdog, clocks
// - stretcher not cleared by power-up
// - pin high releases reset, fetch from vector
// - fetch below 0440 hex causes trap reset
// - fetch from data memory is trap
// - both oscillator enables clear forces reset
// - reset clears bank, irq enables, latches
// - reset clears divider, enables watchdog
// - pc loads vector plus two, high byte FFFF
// - visible pc is fetch address plus two
// - decode 64K space into four regions
// - program memory sits at top
// - top holds reset and interrupt vectors
// - call vector table below interrupt vectors
// - data memory starts 0040 hex
// - 0000 to 00FF is direct area
// - register banks alias 0040 to 00BF
// - reset sets jump status flag
// - watchdog overflow stretches reset on pin
module rst_seq
  import rst_pkg::*;
#(
  parameter int STRETCH_CYCLES = 1 << `RST_STRETCH_EXP,
  parameter logic [15:0] RAM_HI = `RST_RAM_HI_DEF,
  parameter logic [15:0] ROM_LO = `RST_ROM_LO_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic watchdog_overflow,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  output logic core_reset,
  output logic vec_rd,
  output logic [15:0] vec_addr,
  input wire logic [7:0] vec_data,
  output logic [15:0] pc,
  output logic pc_load,
  output logic [2:0] fetch_region,
  output logic direct_area,
  output logic bank_alias,
  output logic ivec_area,
  output logic cvec_area,
  output logic [3:0] bank_selector,
  output logic jump_status_flag,
  output logic master_irq_enable,
  output logic individual_irq_enables,
  output logic pending_irq_latches,
  output logic divider_clear,
  output logic watchdog_enable,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int EXT_CLKS = `RST_EXT_MIN_MCYC * `RST_MCYC_CLKS;

  typedef struct packed {
    rst_state_t st;
    logic [20:0] stretch;
    logic [4:0] ext_cnt;
    logic ext_hold;
    logic [7:0] ctrl;
    logic [3:0] cause;
    logic [7:0] vec_lo;
    logic [15:0] pc;
    logic pc_load;
    logic [15:0] fetch;
    logic aw_got;
    logic [7:0] aw_a;
    logic w_got;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rst_state_s_t;

  rst_state_s_t q;
  rst_state_s_t n;
  logic pin_level;

  // pin input synchroniser
  rst_sync3 u_pin (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pin(reset_pin_in),
    .level(pin_level)
  );

  // classify an address into a memory region
  function automatic logic [2:0] region_of(input logic [15:0] a);
    if (a <= `RST_SFR_HI) begin
      region_of = RST_RG_SFR;
    end else if (a >= `RST_RAM_LO && a <= RAM_HI) begin
      region_of = RST_RG_RAM;
    end else if (a >= ROM_LO) begin
      region_of = RST_RG_ROM;
    end else if (a > RAM_HI && a <= `RST_TRAP_HI) begin
      region_of = RST_RG_DBR;
    end else begin
      region_of = RST_RG_NONE;
    end
  endfunction

  // true when a fetch address must trap
  function automatic logic is_trap(input logic [15:0] a);
    logic r;
    r = (a >= `RST_TRAP_LO && a <= `RST_TRAP_HI);
    r = r | (a >= `RST_RAM_LO && a <= RAM_HI);
    is_trap = r;
  endfunction

  logic trap_hit;
  logic clk_dead;
  logic internal_req;
  logic [7:0] rd_idx;
  logic [31:0] wmask;

  // internal reset sources, read index and write mask
  always_comb begin
    trap_hit = fetch_valid && (q.st == RST_ST_RUN) && is_trap(fetch_addr);
    clk_dead = !q.ctrl[`RST_CTRL_HF_BIT] && !q.ctrl[`RST_CTRL_LF_BIT];
    internal_req = trap_hit || clk_dead ||
                   (watchdog_overflow && q.ctrl[`RST_CTRL_WDT_BIT]);
    rd_idx = s_axi_araddr[7:0];
    wmask = {{8{q.w_s[3]}}, {8{q.w_s[2]}}, {8{q.w_s[1]}}, {8{q.w_s[0]}}};
  end

  // next-state logic
  always_comb begin
    n = q;
    n.pc_load = 1'b0;
    // external pin qualification: low for three machine cycles
    if (pin_level) begin
      n.ext_cnt = '0;
    end else if (q.ext_cnt != 5'(EXT_CLKS)) begin
      n.ext_cnt = q.ext_cnt + 5'd1;
    end
    n.ext_hold = (q.ext_cnt == 5'(EXT_CLKS)) && !pin_level;
    // stretcher counts down while nonzero
    if (internal_req) begin
      n.stretch = 21'(STRETCH_CYCLES);
      n.cause = {watchdog_overflow && q.ctrl[`RST_CTRL_WDT_BIT], clk_dead, trap_hit,
                 1'b0} | q.cause;
    end else if (q.stretch != '0) begin
      n.stretch = q.stretch - 21'd1;
    end
    if (!pin_level && q.ext_cnt == 5'(EXT_CLKS)) begin
      n.cause[0] = 1'b1;
    end
    // escape from deadlocked clocks: reset restores the high-frequency enable only
    if (clk_dead) begin
      n.ctrl[`RST_CTRL_HF_BIT] = 1'b1;
    end
    case (q.st)
      RST_ST_HOLD: begin
        if (q.stretch == '0 && !internal_req && pin_level && !q.ext_hold) begin
          n.st = RST_ST_VLO;
        end
      end
      RST_ST_VLO: begin
        n.vec_lo = vec_data;
        n.st = RST_ST_VHI;
      end
      RST_ST_VHI: begin
        n.pc = {vec_data, q.vec_lo} + `RST_PREFETCH;
        n.pc_load = 1'b1;
        n.st = RST_ST_RUN;
      end
      RST_ST_RUN: begin
        if (fetch_valid) begin
          n.fetch = fetch_addr;
          n.pc = fetch_addr + `RST_PREFETCH;
        end
      end
      default: n.st = RST_ST_HOLD;
    endcase
    if (internal_req || n.ext_hold) begin
      n.st = RST_ST_HOLD;
    end
    // axi write
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.aw_a = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.w_d = s_axi_wdata;
      n.w_s = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RST_RESP_OKAY;
      if (q.aw_a == `RST_REG_CTRL) begin
        n.ctrl = (q.ctrl & ~wmask[7:0]) | (q.w_d[7:0] & wmask[7:0]);
      end else if (q.aw_a == `RST_REG_STAT) begin
        n.cause = n.cause & ~(q.w_d[3:0] & wmask[3:0]);
        // an event in the clearing cycle still lands: set wins over clear
        n.cause = n.cause | {watchdog_overflow && q.ctrl[`RST_CTRL_WDT_BIT], clk_dead, trap_hit,
                             !pin_level && q.ext_cnt == 5'(EXT_CLKS)};
      end else if (q.aw_a != `RST_REG_VEC && q.aw_a != `RST_REG_FETCH &&
                   q.aw_a != `RST_REG_PC && q.aw_a != `RST_REG_CORE) begin
        n.bresp = `RST_RESP_DECERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // axi read
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = `RST_RESP_OKAY;
      if (rd_idx == `RST_REG_CTRL) begin
        n.rdata = {24'h0000_00, q.ctrl};
      end else if (rd_idx == `RST_REG_STAT) begin
        n.rdata = {28'h000_0000, q.cause};
      end else if (rd_idx == `RST_REG_VEC) begin
        n.rdata = {27'h000_0000, q.stretch != '0, q.st};
      end else if (rd_idx == `RST_REG_FETCH) begin
        n.rdata = {13'h0000, region_of(q.fetch), q.fetch};
      end else if (rd_idx == `RST_REG_PC) begin
        n.rdata = {16'h0000, q.pc};
      end else if (rd_idx == `RST_REG_CORE) begin
        n.rdata = {31'h0000_0000, q.st != RST_ST_RUN};
      end else begin
        n.rdata = '0;
        n.rresp = `RST_RESP_DECERR;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  // state register; stretcher starts loaded so power-up may stretch
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= RST_ST_HOLD;
      q.stretch <= 21'(STRETCH_CYCLES);
      q.ctrl <= `RST_CTRL_RESET;
    end else if (clk_en) begin
      q <= n;
    end
  end

  // outputs
  always_comb begin
    s_axi_awready = !q.aw_got;
    s_axi_wready = !q.w_got;
    s_axi_bvalid = q.bvalid;
    s_axi_bresp = q.bresp;
    s_axi_arready = !q.rvalid;
    s_axi_rvalid = q.rvalid;
    s_axi_rdata = q.rdata;
    s_axi_rresp = q.rresp;
    reset_pin_oe = q.stretch != '0;
    reset_pin_out = 1'b0;
    core_reset = q.st != RST_ST_RUN;
    vec_rd = (q.st == RST_ST_VLO) || (q.st == RST_ST_VHI);
    vec_addr = (q.st == RST_ST_VHI) ? `RST_VEC_HI : `RST_VEC_LO;
    pc = q.pc;
    pc_load = q.pc_load;
    fetch_region = region_of(q.fetch);
    direct_area = q.fetch <= `RST_DIRECT_HI;
    bank_alias = q.fetch >= `RST_RAM_LO && q.fetch <= `RST_BANK_HI;
    ivec_area = q.fetch >= `RST_IVEC_LO;
    cvec_area = q.fetch >= `RST_CVEC_LO && q.fetch < `RST_IVEC_LO;
    // initial values held while in reset
    bank_selector = 4'h0;
    master_irq_enable = 1'b0;
    individual_irq_enables = 1'b0;
    pending_irq_latches = 1'b0;
    jump_status_flag = core_reset;
    divider_clear = core_reset;
    watchdog_enable = 1'b1;
  end
endmodule

//--- bench/rst_seq_props.sv
module rst_seq_props
  import rst_pkg::*;
#(
  parameter int STRETCH_CYCLES = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic watchdog_overflow,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic core_reset,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  input wire logic [15:0] pc,
  input wire logic pc_load,
  input wire logic [3:0] bank_selector,
  input wire logic master_irq_enable,
  input wire logic jump_status_flag
);
  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // cycles the pin has been sunk in a row
  int oe_cnt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_cnt <= 0;
    end else begin
      oe_cnt <= reset_pin_oe ? oe_cnt + 1 : 0;
    end
  end
  // low vector byte, then high vector byte
  sequence s_vec;
    vec_rd && vec_addr == 16'hFFFE ##1 vec_rd && vec_addr == 16'hFFFF;
  endsequence
  a_pin_sinks_only: assert property (reset_pin_oe |-> !reset_pin_out)
    else $error("reset pin driven high");
  a_oe_holds_core: assert property (reset_pin_oe |-> core_reset)
    else $error("core ran while pin sunk");
  a_stretch_length: assert property ($fell(reset_pin_oe) |->
    oe_cnt >= STRETCH_CYCLES - 2 && oe_cnt <= STRETCH_CYCLES + 2)
    else $error("stretch length wrong");
  a_vec_then_load: assert property (s_vec |-> ##[1:3] pc_load)
    else $error("no pc load after vector");
  a_load_pulse: assert property (pc_load |=> !pc_load)
    else $error("pc load longer than one cycle");
  a_reset_state: assert property (core_reset |-> bank_selector == 4'h0 &&
    !master_irq_enable && jump_status_flag)
    else $error("reset state wrong");
  a_trap_fetch: assert property (fetch_valid && !core_reset &&
    fetch_addr <= 16'h043F |-> ##[1:6] reset_pin_oe)
    else $error("no trap reset");
  a_pc_ahead: assert property (fetch_valid && !core_reset &&
    fetch_addr[15:13] == 3'b111 |=> pc == $past(fetch_addr) + 16'h0002)
    else $error("pc not two ahead");
  a_wdt_reset: assert property (watchdog_overflow && !core_reset |->
    ##[1:6] reset_pin_oe)
    else $error("no watchdog reset");
endmodule
bind rst_seq rst_seq_props #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .reset_pin_out(reset_pin_out),
  .reset_pin_oe(reset_pin_oe), .watchdog_overflow(watchdog_overflow),
  .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .core_reset(core_reset),
  .vec_rd(vec_rd), .vec_addr(vec_addr), .pc(pc), .pc_load(pc_load),
  .bank_selector(bank_selector), .master_irq_enable(master_irq_enable),
  .jump_status_flag(jump_status_flag)
);

//--- bench/rst_brd.sv
module rst_brd #(
  parameter logic [15:0] VEC = 16'hC03E
) (
  input wire logic hold_low,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  output logic reset_pin_in,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  output logic [7:0] vec_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // pulled-up pin, low when either side sinks it
  assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || hold_low);
  // vector bytes; when not read the lines show the inverted low address byte
  assign vec_data = !vec_rd ? ~vec_addr[7:0] : (vec_addr[0] ? VEC[15:8] : VEC[7:0]);
endmodule

//--- bench/tb_top.sv
module tb_top
  import rst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] VEC = 16'hC03E;
  logic sys_clk = 0, rst_b = 0, hold = 0, wdo = 0, fv = 0;
  logic pin_in, pin_out, pin_oe, core_reset, vec_rd, pc_load;
  logic [15:0] fa = 0, vec_addr, pc;
  logic [7:0] vec_data;
  logic [2:0] region;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  int bad_count = 0, comparisons = 0;
  logic [15:0] traps [3] = '{16'h0000, 16'h0050, 16'h043F};
  always #50 sys_clk = ~sys_clk;
  rst_brd #(.VEC(VEC)) u_brd (.hold_low(hold), .reset_pin_out(pin_out),
    .reset_pin_oe(pin_oe), .reset_pin_in(pin_in), .vec_rd(vec_rd),
    .vec_addr(vec_addr), .vec_data(vec_data));
  rst_seq #(.STRETCH_CYCLES(16)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
    .reset_pin_in(pin_in), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
    .watchdog_overflow(wdo), .fetch_valid(fv), .fetch_addr(fa), .core_reset(core_reset),
    .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_data(vec_data), .pc(pc), .pc_load(pc_load),
    .fetch_region(region), .direct_area(), .bank_alias(), .ivec_area(), .cvec_area(),
    .bank_selector(), .jump_status_flag(), .master_irq_enable(),
    .individual_irq_enables(), .pending_irq_latches(), .divider_clear(),
    .watchdog_enable(), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timeout;
    chk(32'd0, 32'd1);
    final_report;
  endtask
  // bounded wait for the core reset level
  task automatic wait_for(input logic want);
    for (int n = 0; core_reset !== want; n++) begin
      if (n > 400) timeout;
      @(posedge sys_clk);
    end
  endtask
  // reset entered, left, and the vector loaded
  task automatic recover;
    wait_for(1'b1);
    wait_for(1'b0);
    @(posedge sys_clk);
    chk(pc, VEC + 16'h0002);
  endtask
  task automatic fetch(input logic [15:0] a);
    @(posedge sys_clk);
    fv <= 1'b1;
    fa <= a;
    @(posedge sys_clk);
    fv <= 1'b0;
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
    logic k;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    for (int n = 0; n < 50 && !k; n++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        k = 1;
      end
    end
    if (!k) timeout;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    logic k;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    for (int n = 0; n < 50 && !k; n++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        k = 1;
      end
    end
    if (!k) timeout;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    recover;
    $display("power-up test done");
    fetch(16'hE123);
    @(posedge sys_clk);
    chk(pc, 16'hE125);
    chk(region, RST_RG_ROM);
    axi_rd(32'h0000_0000);
    chk(d[7:0], 8'hC1);
    axi_rd(32'h0000_0040);
    chk(r, 2'b11);
    $display("fetch and register test done");
    foreach (traps[i]) begin
      fetch(traps[i]);
      recover;
    end
    $display("trap test done");
    @(posedge sys_clk);
    wdo <= 1'b1;
    @(posedge sys_clk);
    wdo <= 1'b0;
    recover;
    $display("watchdog test done");
    @(posedge sys_clk);
    hold <= 1'b1;
    repeat (24) @(posedge sys_clk);
    chk(core_reset, 1'b1);
    hold <= 1'b0;
    recover;
    $display("pin test done");
    axi_wr(32'h0000_0000, 32'h0000_0001);
    chk(r, 2'b00);
    recover;
    axi_rd(32'h0000_0000);
    chk(d[7], 1'b1);
    axi_rd(32'h0000_0004);
    chk(d, 32'h0000_000F);
    axi_wr(32'h0000_0004, 32'h0000_000F);
    chk(r, 2'b00);
    axi_rd(32'h0000_0004);
    chk(d, 32'h0000_0000);
    $display("clock stop test done");
    final_report;
  end
endmodule
